// ===== common/msq_pkg.sv
package msq_pkg;
  localparam int WORD_W = 24;
  localparam int ADDR_W = 12;
  localparam int LOW_W = 15;
  localparam int BYTE_W = 8;
  localparam int M_LSB = 18;
  localparam int TM_LSB = 12;
  localparam int STOPS = 3;
  localparam logic [2:0] M_FULL = 3'h0;
  localparam logic [2:0] M_LOW = 3'h4;
  localparam logic [2:0] TM_INC = 3'h1;
  localparam logic [2:0] TM_DEC = 3'h2;
  localparam logic [ADDR_W-1:0] TRACE_ADDR = 12'h000;
  localparam logic [ADDR_W-1:0] P_RESET = 12'h000;
  localparam logic [1:0] RJ_GATE_CYC = 2'h2;
  localparam int CLK_NS = 40;
  localparam int STOP_NS = 4000;
  localparam int STOP_CYC = STOP_NS / CLK_NS;

  typedef struct packed {
    logic start;
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [WORD_W-1:0] wdata;
  } msq_mem_req_t;

  typedef struct packed {
    logic write;
    logic jump;
    logic rjump;
    logic trace;
    logic skip;
    logic done;
    logic stop;
  } msq_req_t;
endpackage

// ===== rtl/msq_sequencer.sv
`timescale 1ns/1ns
`default_nettype none
module msq_sequencer #(
  parameter int STOP_CYCLES = msq_pkg::STOP_CYC
) (
  // clock and reset
  input wire logic clock_in,
  input wire logic nrst_in,
  // command timing and instruction requests
  input wire logic cmd_step_in,
  input wire msq_pkg::msq_req_t req_in,
  input wire logic [msq_pkg::WORD_W-1:0] operand_in,
  input wire logic shift_nz_in,
  input wire logic shift_ctl_in,
  // repeat tally load
  input wire logic repeat_set_in,
  input wire logic tally_wr_in,
  input wire logic [msq_pkg::LOW_W-1:0] tally_in,
  // core memory
  input wire logic mem_resume_in,
  input wire logic mem_rvalid_in,
  input wire logic [msq_pkg::WORD_W-1:0] mem_rdata_in,
  output msq_pkg::msq_mem_req_t mem_out,
  // stop switches and resync timing
  input wire logic [msq_pkg::STOPS:1] stop_sw_in,
  input wire logic resync_pulse_in,
  input wire logic resync_clear_pulse_in,
  input wire logic stop_clear_in,
  // state seen by the datapath
  output logic [msq_pkg::WORD_W-1:0] order_out,
  output logic [msq_pkg::ADDR_W-1:0] loc_out,
  output logic [msq_pkg::LOW_W-1:0] tally_out,
  output logic repeat_again_out,
  output logic busy_out,
  output logic [msq_pkg::STOPS:0] stop_ind_out,
  output logic stop_pulse_out
);
  import msq_pkg::*;

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  // the pulse spacing check needs at least eight quiet cycles between pulses
  if (STOP_CYCLES < 9 || STOP_CYCLES > 255) begin : g_bad_stop
    $error("STOP_CYCLES must lie in 9..255");
  end

  typedef enum logic [3:0] {
    ST_IDLE, ST_WSTART, ST_WREAD, ST_WBACK,
    ST_FINC, ST_FSTART, ST_FREAD, ST_FBACK, ST_FXFER,
    ST_PINC, ST_SKIP1, ST_SKIP2
  } msq_state_t;

  msq_state_t state_q;
  logic res_s1_q, res_s2_q, res_s3_q;
  logic [STOPS:1] sw_s1_q, sw_s2_q, rsy_q, ss_q;
  logic wr_pend_q, fe_pend_q, resume_q, xfer_q, jmp_pend_q, rep_q;
  logic rj_q, tr_q, got_q;
  logic [1:0] cyc_q;
  logic [ADDR_W-1:0] s_q, p_q;
  logic [WORD_W-1:0] u_q, z_q;
  logic [LOW_W-1:0] tally_q;
  logic [STOPS:0] ind_q, ind_set;
  logic [7:0] stop_cnt_q;
  logic stop_pulse_q;
  logic idle, go_wr, go_fe, go_jp, res_edge, rd_ok, gate_ok, w_done;
  logic rep_go, end_go, stop_any;
  logic [2:0] m_sel, tm_sel;

  // ----------------------------------------------------------------
  // merge of operand into the stored word
  // ----------------------------------------------------------------
  function automatic logic [WORD_W-1:0] merge(
    input logic [WORD_W-1:0] old,
    input logic [WORD_W-1:0] opd,
    input logic [2:0] m
  );
    logic [WORD_W-1:0] w;
    w = old;
    if (m == M_FULL) begin
      w = opd;
    end else if (m == M_LOW) begin
      w[LOW_W-1:0] = opd[LOW_W-1:0];
    end else begin
      w[BYTE_W*(int'(m[1:0])-1) +: BYTE_W] = opd[BYTE_W-1:0];
    end
    return w;
  endfunction

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  assign m_sel = u_q[M_LSB +: 3];
  assign tm_sel = tally_q[TM_LSB +: 3];
  assign idle = (state_q == ST_IDLE);
  assign res_edge = res_s2_q & ~res_s3_q;
  assign stop_any = |ind_q;
  // memory cycles begin only with resume seen
  assign go_wr = idle & cmd_step_in & wr_pend_q & resume_q;
  // a pending stop indication delays the next fetch
  assign go_fe = idle & cmd_step_in & fe_pend_q & resume_q & ~go_wr
    & ~stop_any;
  assign go_jp = idle & cmd_step_in & jmp_pend_q & ~go_wr & ~go_fe;
  assign end_go = idle & req_in.done & ~go_wr & ~go_fe & ~go_jp;
  assign rep_go = end_go & rep_q & (tally_q != '0);
  assign rd_ok = mem_rvalid_in | got_q;
  assign gate_ok = ~rj_q | (cyc_q == RJ_GATE_CYC);
  assign w_done = (state_q == ST_WREAD) & rd_ok & gate_ok;

  // bit 0 stops on selector 0 or 4 whatever the switches say
  assign ind_set[0] = end_go & req_in.stop & (m_sel[1:0] == 2'h0);

  // ----------------------------------------------------------------
  // synchronisers for memory resume and stop switches
  // ----------------------------------------------------------------
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      res_s1_q <= 1'b0;
      res_s2_q <= 1'b0;
      res_s3_q <= 1'b0;
      sw_s1_q <= '0;
      sw_s2_q <= '0;
    end else begin
      res_s1_q <= mem_resume_in;
      res_s2_q <= res_s1_q;
      res_s3_q <= res_s2_q;
      sw_s1_q <= stop_sw_in;
      sw_s2_q <= sw_s1_q;
    end
  end

  // ----------------------------------------------------------------
  // sequence state
  // ----------------------------------------------------------------
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_q <= ST_IDLE;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (go_wr) begin
            state_q <= ST_WSTART;
          end else if (go_fe) begin
            state_q <= ST_FINC;
          end else if (go_jp && rj_q) begin
            state_q <= ST_PINC;
          end else if (req_in.skip && !end_go) begin
            state_q <= ST_SKIP1;
          end
        end
        ST_WSTART: state_q <= ST_WREAD;
        ST_WREAD: begin
          if (w_done) begin
            state_q <= ST_WBACK;
          end
        end
        ST_WBACK: state_q <= ST_IDLE;
        ST_FINC: state_q <= ST_FSTART;
        ST_FSTART: state_q <= ST_FREAD;
        ST_FREAD: begin
          if (mem_rvalid_in) begin
            state_q <= ST_FBACK;
          end
        end
        ST_FBACK: state_q <= ST_FXFER;
        ST_FXFER: begin
          if (!(shift_nz_in && shift_ctl_in)) begin
            state_q <= ST_IDLE;
          end
        end
        ST_PINC: state_q <= ST_IDLE;
        ST_SKIP1: state_q <= ST_SKIP2;
        ST_SKIP2: state_q <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // pending bits; a set in the clearing cycle wins
  // ----------------------------------------------------------------
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wr_pend_q <= 1'b0;
      fe_pend_q <= 1'b1;
      resume_q <= 1'b0;
      jmp_pend_q <= 1'b0;
      xfer_q <= 1'b0;
      rep_q <= 1'b0;
    end else begin
      wr_pend_q <= req_in.write | req_in.rjump | (wr_pend_q & ~go_wr);
      resume_q <= res_edge | (resume_q & ~go_wr & ~go_fe);
      jmp_pend_q <= req_in.jump | (state_q == ST_WBACK && rj_q)
        | (jmp_pend_q & ~go_jp);
      fe_pend_q <= (end_go & ~rep_go)
        | (go_jp & ~rj_q) | (state_q == ST_PINC)
        | (state_q == ST_SKIP2)
        | (fe_pend_q & ~go_fe);
      if (state_q == ST_FBACK) begin
        xfer_q <= 1'b1;
      end else if (state_q == ST_FXFER && !(shift_nz_in && shift_ctl_in)) begin
        xfer_q <= 1'b0;
      end
      if (repeat_set_in) begin
        rep_q <= 1'b1;
      end else if (end_go && !rep_go) begin
        rep_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // return jump and trace bookkeeping
  // ----------------------------------------------------------------
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rj_q <= 1'b0;
      tr_q <= 1'b0;
    end else if (req_in.rjump) begin
      rj_q <= 1'b1;
      tr_q <= req_in.trace;
    end else if (state_q == ST_PINC) begin
      rj_q <= 1'b0;
      tr_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // memory read tracking
  // ----------------------------------------------------------------
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cyc_q <= 2'h0;
      got_q <= 1'b0;
    end else if (state_q == ST_WSTART) begin
      cyc_q <= 2'h0;
      got_q <= 1'b0;
    end else if (state_q == ST_WREAD) begin
      if (cyc_q != RJ_GATE_CYC) begin
        cyc_q <= cyc_q + 2'h1;
      end
      got_q <= got_q | mem_rvalid_in;
    end
  end

  // ----------------------------------------------------------------
  // locator and location counter
  // ----------------------------------------------------------------
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      s_q <= '0;
    end else if (go_wr) begin
      // trace blocks the order-to-locator path
      s_q <= tr_q ? TRACE_ADDR : u_q[ADDR_W-1:0];
    end else if (go_fe) begin
      s_q <= p_q;
    end
  end

  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      p_q <= P_RESET;
    end else if (go_jp) begin
      p_q <= tr_q ? TRACE_ADDR : u_q[ADDR_W-1:0];
    end else if (state_q == ST_FINC || state_q == ST_PINC
        || state_q == ST_SKIP1 || state_q == ST_SKIP2) begin
      p_q <= p_q + 12'h001;
    end
  end

  // ----------------------------------------------------------------
  // buffer and order register
  // ----------------------------------------------------------------
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      z_q <= '0;
    end else if (state_q == ST_WREAD) begin
      if (rj_q && cyc_q == RJ_GATE_CYC - 2'h1) begin
        z_q <= {{(WORD_W-ADDR_W){1'b0}}, p_q};
      end else if (mem_rvalid_in && !rj_q) begin
        z_q <= merge(mem_rdata_in, operand_in, m_sel);
      end
    end else if (state_q == ST_FREAD && mem_rvalid_in) begin
      z_q <= mem_rdata_in;
    end
  end

  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      u_q <= '0;
    end else if (state_q == ST_FXFER && !(shift_nz_in && shift_ctl_in)) begin
      u_q <= z_q;
    end else if (rep_go && tm_sel == TM_INC) begin
      u_q[LOW_W-1:0] <= u_q[LOW_W-1:0] + 15'h0001;
    end else if (rep_go && tm_sel == TM_DEC) begin
      u_q[LOW_W-1:0] <= u_q[LOW_W-1:0] - 15'h0001;
    end
  end

  // ----------------------------------------------------------------
  // repeat tally
  // ----------------------------------------------------------------
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      tally_q <= '0;
    end else if (tally_wr_in) begin
      tally_q <= tally_in;
    end else if (rep_go) begin
      tally_q <= tally_q - 15'h0001;
    end
  end

  // ----------------------------------------------------------------
  // selective stop switches, one lane per switch
  // ----------------------------------------------------------------
  for (genvar k = 1; k <= STOPS; k++) begin : g_stop
    always_ff @(posedge clock_in or negedge nrst_in) begin
      if (!nrst_in) begin
        rsy_q[k] <= 1'b0;
        ss_q[k] <= 1'b0;
      end else begin
        if (resync_pulse_in) begin
          rsy_q[k] <= sw_s2_q[k];
        end
        // set wins over the clear pulse
        if (resync_pulse_in && rsy_q[k]) begin
          ss_q[k] <= 1'b1;
        end else if (resync_clear_pulse_in) begin
          ss_q[k] <= 1'b0;
        end
      end
    end
    assign ind_set[k] = end_go & req_in.stop & ss_q[k]
      & (m_sel[1:0] == 2'(k));
  end

  // ----------------------------------------------------------------
  // stop indication and periodic stop pulse
  // ----------------------------------------------------------------
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ind_q <= '0;
    end else begin
      ind_q <= ind_set | (ind_q & {(STOPS+1){~stop_clear_in}});
    end
  end

  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      stop_cnt_q <= 8'h00;
      stop_pulse_q <= 1'b0;
    end else if (!stop_any) begin
      stop_cnt_q <= 8'h00;
      stop_pulse_q <= 1'b0;
    end else begin
      // first pulse at once, then one per period
      stop_pulse_q <= (stop_cnt_q == 8'h00);
      if (stop_cnt_q == 8'(STOP_CYCLES - 1)) begin
        stop_cnt_q <= 8'h00;
      end else begin
        stop_cnt_q <= stop_cnt_q + 8'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign mem_out.start = (state_q == ST_WSTART) | (state_q == ST_FSTART);
  assign mem_out.wr = (state_q == ST_WBACK) | (state_q == ST_FBACK);
  assign mem_out.addr = s_q;
  assign mem_out.wdata = z_q;
  assign order_out = u_q;
  assign loc_out = p_q;
  assign tally_out = tally_q;
  assign repeat_again_out = rep_go;
  assign busy_out = ~idle;
  assign stop_ind_out = ind_q;
  assign stop_pulse_out = stop_pulse_q;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!nrst_in);

  sequence s_fetch_go;
    go_fe && !res_edge;
  endsequence
  sequence s_fetch_steps;
    (s_q == $past(p_q)) ##1 (p_q == s_q + 12'h001 && mem_out.start);
  endsequence

  a_write_go: assert property (go_wr && !res_edge && !req_in.write
    && !req_in.rjump |=> state_q == ST_WSTART && !wr_pend_q && !resume_q)
    else $error("write start did not clear pending bits");
  a_write_addr: assert property (go_wr && !tr_q
    |=> s_q == $past(u_q[ADDR_W-1:0]))
    else $error("write locator not from order");
  a_merge_full: assert property (state_q == ST_WREAD && mem_rvalid_in
    && !rj_q && m_sel == M_FULL |=> z_q == $past(operand_in))
    else $error("full word write lost operand");
  a_write_back: assert property (w_done
    |=> mem_out.wr && mem_out.addr == $past(s_q))
    else $error("write back not in next cycle");
  a_fetch_order: assert property (s_fetch_go |=> s_fetch_steps)
    else $error("fetch order wrong");
  a_fetch_restore: assert property (state_q == ST_FREAD && mem_rvalid_in
    |=> mem_out.wr && mem_out.wdata == $past(mem_rdata_in))
    else $error("fetched word not restored");
  a_xfer_hold: assert property (state_q == ST_FXFER && shift_nz_in
    && shift_ctl_in |=> state_q == ST_FXFER && xfer_q && $stable(u_q))
    else $error("transfer not held during shift");
  a_repeat_dec: assert property (rep_go && !tally_wr_in
    |=> tally_q == $past(tally_q) - 15'h0001)
    else $error("tally not decremented");
  a_skip_twice: assert property (state_q == ST_SKIP1
    |-> ##2 p_q == $past(p_q, 2) + 12'h002 && fe_pend_q)
    else $error("skip did not advance by two");
  a_rj_gate: assert property (rj_q && state_q == ST_WSTART
    |-> ##3 z_q[ADDR_W-1:0] == p_q)
    else $error("counter not gated two cycles after start");
  a_stop_clear: assert property (resync_clear_pulse_in && !resync_pulse_in
    |=> ss_q == '0)
    else $error("selective stop bits not cleared");
  a_stop_period: assert property (stop_pulse_out
    |=> !stop_pulse_out [*8])
    else $error("stop pulses too close");
endmodule // msq_sequencer
`default_nettype wire

// ===== dv/msq_mem_model.sv
`timescale 1ns/1ns
`default_nettype none
module msq_mem_model #(
  parameter int LAT = 3
) (
  // clock and reset
  input wire logic clock_in,
  input wire logic nrst_in,
  // sequencer side
  input wire msq_pkg::msq_mem_req_t mem_in,
  output logic resume_out,
  output logic rvalid_out,
  output logic [msq_pkg::WORD_W-1:0] rdata_out
);
  import msq_pkg::*;
  logic [WORD_W-1:0] words [0:(1<<ADDR_W)-1];
  int lat_q;
  int rec_q;
  // ----------------------------------------
  // read-restore cycle
  // ----------------------------------------
  always @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      resume_out <= 1'b0;
      rvalid_out <= 1'b0;
      rdata_out <= 24'h000000;
      lat_q <= 0;
      rec_q <= 4;
    end else begin
      rvalid_out <= 1'b0;
      // released data lines toggle so stale values never look valid
      rdata_out <= ~rdata_out;
      if (mem_in.start) begin
        resume_out <= 1'b0;
        lat_q <= LAT;
      end else if (lat_q == 1) begin
        rvalid_out <= 1'b1;
        rdata_out <= words[mem_in.addr];
        lat_q <= 0;
      end else if (lat_q > 1) begin
        lat_q <= lat_q - 1;
      end
      if (mem_in.wr) begin
        words[mem_in.addr] <= mem_in.wdata;
        rec_q <= 3;
      end else if (rec_q == 1) begin
        resume_out <= 1'b1;
        rec_q <= 0;
      end else if (rec_q > 1) begin
        rec_q <= rec_q - 1;
      end
    end
  end
endmodule // msq_mem_model
`default_nettype wire

// ===== dv/msq_sequencer_bench.sv
`timescale 1ns/1ns
`default_nettype none
module msq_sequencer_bench;
  import msq_pkg::*;
  localparam int STOP_N = 10;
  localparam logic [WORD_W-1:0] ORIG = 24'hA5C3E1;
  localparam logic [WORD_W-1:0] OPD = 24'h5A3C7E;
  logic clock_in = 1'b0;
  logic nrst_in = 1'b0;
  logic cmd_step_in = 1'b0;
  msq_req_t req_in = '0;
  logic shift_nz_in = 1'b0;
  logic shift_ctl_in = 1'b0;
  logic repeat_set_in = 1'b0;
  logic tally_wr_in = 1'b0;
  logic [LOW_W-1:0] tally_in = 15'h0000;
  logic [STOPS:1] stop_sw_in = 3'h0;
  logic resync_in = 1'b0;
  logic rsy_clr_in = 1'b0;
  logic stop_clear_in = 1'b0;
  logic mem_resume, mem_rvalid;
  logic [WORD_W-1:0] mem_rdata, order_out;
  msq_mem_req_t mem_o;
  logic [ADDR_W-1:0] loc_out;
  logic [LOW_W-1:0] tally_out;
  logic again_out, busy_out, stop_pulse_out;
  logic [STOPS:0] stop_ind_out;
  int err_count = 0;
  int tests_run = 0;
  int k;
  always #20 clock_in = ~clock_in;
  msq_sequencer #(.STOP_CYCLES(STOP_N)) uut (.clock_in(clock_in),
    .nrst_in(nrst_in), .cmd_step_in(cmd_step_in), .req_in(req_in),
    .operand_in(OPD), .shift_nz_in(shift_nz_in),
    .shift_ctl_in(shift_ctl_in), .repeat_set_in(repeat_set_in),
    .tally_wr_in(tally_wr_in), .tally_in(tally_in),
    .mem_resume_in(mem_resume), .mem_rvalid_in(mem_rvalid),
    .mem_rdata_in(mem_rdata), .mem_out(mem_o), .stop_sw_in(stop_sw_in),
    .resync_pulse_in(resync_in), .resync_clear_pulse_in(rsy_clr_in),
    .stop_clear_in(stop_clear_in), .order_out(order_out),
    .loc_out(loc_out), .tally_out(tally_out),
    .repeat_again_out(again_out), .busy_out(busy_out),
    .stop_ind_out(stop_ind_out), .stop_pulse_out(stop_pulse_out));
  msq_mem_model #(.LAT(3)) mem_i (.clock_in(clock_in), .nrst_in(nrst_in),
    .mem_in(mem_o), .resume_out(mem_resume), .rvalid_out(mem_rvalid),
    .rdata_out(mem_rdata));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [WORD_W-1:0] instr(input int i);
    return {3'h0, i[2:0], 6'h00, 12'h100 + i[11:0]};
  endfunction
  function automatic logic [WORD_W-1:0] merge(input logic [WORD_W-1:0] o,
      input logic [WORD_W-1:0] d, input logic [2:0] m);
    logic [WORD_W-1:0] w;
    w = o;
    case (m)
      3'h0: w = d;
      3'h4: w[14:0] = d[14:0];
      3'h1, 3'h5: w[7:0] = d[7:0];
      3'h2, 3'h6: w[15:8] = d[7:0];
      default: w[23:16] = d[7:0];
    endcase
    return w;
  endfunction
  task automatic check(input string what, input logic [WORD_W-1:0] exp,
      input logic [WORD_W-1:0] got);
    tests_run++;
    if (got !== exp) begin
      $display("unexpected %s: expected %h seen %h", what, exp, got);
      err_count++;
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock_in);
    #2;
  endtask
  // resume needs its synchroniser to settle before each step
  task automatic step();
    tick(8);
    cmd_step_in = 1'b1;
    tick(1);
    cmd_step_in = 1'b0;
    tick(1);
    for (k = 0; k < 40 && busy_out === 1'b1; k++) tick(1);
  endtask
  task automatic pulse_req(input msq_req_t r);
    req_in = r;
    tick(1);
    req_in = '0;
  endtask
  task automatic done(input logic stp);
    msq_req_t r;
    r = '0;
    r.done = 1'b1;
    r.stop = stp;
    pulse_req(r);
  endtask
  task automatic pulse_sync(input logic clr);
    resync_in = ~clr;
    rsy_clr_in = clr;
    tick(1);
    resync_in = 1'b0;
    rsy_clr_in = 1'b0;
    tick(1);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_writes();
    msq_req_t r;
    r = '0;
    r.write = 1'b1;
    step();
    check("first order", instr(0), order_out);
    for (int i = 0; i < 8; i++) begin
      pulse_req(r);
      step();
      check("merged word", merge(ORIG, OPD, i), mem_i.words[12'h100 + i]);
      done(1'b0);
      if (i == 3) begin
        shift_nz_in = 1'b1;
        shift_ctl_in = 1'b1;
      end
      step();
      if (i == 3) begin
        check("held order", instr(3), order_out);
        shift_nz_in = 1'b0;
        tick(3);
      end
      check("order", instr(i + 1), order_out);
      check("loc", i + 2, loc_out);
      check("restored", instr(i + 1), mem_i.words[i + 1]);
    end
  endtask
  task automatic t_repeat();
    for (int s = 1; s < 3; s++) begin
      tally_in = {s[2:0], 12'h001};
      tally_wr_in = 1'b1;
      repeat_set_in = 1'b1;
      tick(1);
      tally_wr_in = 1'b0;
      repeat_set_in = 1'b0;
      req_in.done = 1'b1;
      #10;
      check("again", 1'b1, again_out);
      tick(1);
      req_in = '0;
      tick(1);
      // the selector field is part of the tally, so one repeat leaves it set
      check("tally", {s[2:0], 12'h000}, tally_out);
      check("order step", instr(8) + (s == 1), order_out);
    end
    // a cleared tally ends the repeat run
    tally_in = 15'h0000;
    tally_wr_in = 1'b1;
    tick(1);
    tally_wr_in = 1'b0;
    req_in.done = 1'b1;
    #10;
    check("no again", 1'b0, again_out);
    tick(1);
    req_in = '0;
    step();
    check("fetch after repeat", 10, loc_out);
  endtask
  task automatic t_jumps(input logic tr, input logic [ADDR_W-1:0] tgt);
    msq_req_t r;
    logic [WORD_W-1:0] exp_st;
    r = '0;
    r.skip = ~tr;
    if (!tr) begin
      pulse_req(r);
      tick(4);
      check("skip loc", 12, loc_out);
      step();
      r = '0;
      r.jump = 1'b1;
      pulse_req(r);
      step();
      check("jump loc", 12'h020, loc_out);
      step();
      r = '0;
    end
    r.rjump = 1'b1;
    r.trace = tr;
    pulse_req(r);
    step();
    // counter value reached by the fetches that precede each return jump
    exp_st = tr ? 24'h000042 : 24'h000021;
    check("stored loc", exp_st, mem_i.words[tgt]);
    step();
    tick(2);
    check("rj loc", tgt + 1, loc_out);
    step();
  endtask
  task automatic t_stop();
    int n;
    n = 0;
    stop_sw_in = 3'h1;
    tick(4);
    pulse_sync(1'b0);
    pulse_sync(1'b0);
    pulse_sync(1'b1);
    done(1'b1);
    tick(2);
    check("cleared stop", 4'h0, stop_ind_out);
    pulse_sync(1'b0);
    pulse_sync(1'b0);
    done(1'b1);
    check("stop ind", 4'h2, stop_ind_out);
    repeat (35) begin
      n += (stop_pulse_out === 1'b1);
      tick(1);
    end
    check("stop pulses", 4, n);
    stop_clear_in = 1'b1;
    tick(1);
    stop_clear_in = 1'b0;
    tick(1);
    check("stop off", 4'h0, stop_ind_out);
    // lanes 2 and 3 have no switch set; selector 4 stops regardless
    for (int i = 2; i < 5; i++) begin
      step();
      done(1'b1);
      check("stop sel", (i == 4) ? 4'h1 : 4'h0, stop_ind_out);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    for (int a = 0; a < 4096; a++) mem_i.words[a] = instr(a % 16);
    for (int a = 0; a < 8; a++) mem_i.words[12'h100 + a] = ORIG;
    mem_i.words[12] = 24'h000020;
    mem_i.words[12'h020] = 24'h000040;
    repeat (5) @(posedge clock_in);
    #2;
    nrst_in = 1'b1;
    check("reset loc", 12'h000, loc_out);
    check("reset busy", 1'b0, busy_out);
    t_writes();
    t_repeat();
    t_jumps(1'b0, 12'h040);
    t_jumps(1'b1, TRACE_ADDR);
    check("trace order", instr(1), order_out);
    t_stop();
    end_of_test();
  end
  initial begin
    #(40 * 20000);
    err_count++;
    end_of_test();
  end
endmodule // msq_sequencer_bench
`default_nettype wire
